/* logic/periodic_tick_and_pulse_counter.sv */
module periodic_tick_and_pulse_counter import tick_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int TICK_BASE_SHIFT = TICK_BASE_SHIFT_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic accum_input_pin,
  input wire logic main_count_wrap,
  output logic irq,
  output logic [1:0] main_prescale_select,
  output logic capture4_compare5_select
);
  localparam int DIV_W = TICK_BASE_SHIFT + TICK_RATE_STEPS;

  // elaboration check on parameters
  if (ADDR_W < 8 || TICK_BASE_SHIFT < 1 || TICK_BASE_SHIFT > 24) begin : g_bad_param
    $error("unsupported parameter value");
  end

  // address decode shared by read and write paths
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:IDX_LSB] == (ADDR_W-IDX_LSB)'(IDX_MASK)) s = SEL_MASK;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:IDX_LSB] == (ADDR_W-IDX_LSB)'(IDX_FLAG)) s = SEL_FLAG;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:IDX_LSB] == (ADDR_W-IDX_LSB)'(IDX_CTRL)) s = SEL_CTRL;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:IDX_LSB] == (ADDR_W-IDX_LSB)'(IDX_COUNT)) s = SEL_COUNT;
    return s;
  endfunction

  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  mask_t mask_reg, mask_next;
  ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] flag_reg, flag_next;
  logic [7:0] count_reg, count_next;
  logic [DIV_W-1:0] tick_div_reg;
  logic [GATE_DIV_W-1:0] gate_div_reg;
  logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic irq_reg;

  // write channel handshake and decode
  wire aw_take = awvalid && awready_reg;
  wire w_take = wvalid && wready_reg;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire reg_sel_t wr_sel = decode(awaddr_reg);
  wire wr_en = wr_fire && wstrb0_reg;
  wire wr_mask = wr_en && wr_sel == SEL_MASK;
  wire wr_flag = wr_en && wr_sel == SEL_FLAG;
  wire wr_ctrl = wr_en && wr_sel == SEL_CTRL;
  wire wr_count = wr_en && wr_sel == SEL_COUNT;
  assign aw_held_next = (aw_held_reg && !wr_fire) || aw_take;
  assign w_held_next = (w_held_reg && !wr_fire) || w_take;

  // read channel decode
  wire ar_take = arvalid && arready_reg;
  wire reg_sel_t rd_sel = decode(araddr);
  wire [7:0] rd_byte = rd_sel == SEL_MASK ? 8'(mask_reg) & MASK_WMASK :
                       rd_sel == SEL_FLAG ? flag_reg & FLAG_MASK :
                       rd_sel == SEL_CTRL ? 8'(ctrl_reg) & CTRL_WMASK :
                       rd_sel == SEL_COUNT ? count_reg : 8'h00;

  // periodic timeout: low (base + rate) divider bits all ones
  wire [DIV_W:0] rate_bit = (DIV_W+1)'(1) << (TICK_BASE_SHIFT + int'(ctrl_reg.tick_rate_select));
  wire [DIV_W-1:0] rate_mask = DIV_W'(rate_bit - (DIV_W+1)'(1));
  wire periodic_timeout = (tick_div_reg & rate_mask) == rate_mask;

  // accumulator input conditioning
  wire pin_rise = pin_sync_reg && !pin_prev_reg;
  wire pin_fall = !pin_sync_reg && pin_prev_reg;
  wire sel_edge = ctrl_reg.accum_edge_select ? pin_rise : pin_fall;
  wire gate_active = pin_sync_reg ^ ctrl_reg.accum_edge_select;
  wire gate_tick = &gate_div_reg;
  wire count_inc = ctrl_reg.accum_enable &&
                   (ctrl_reg.accum_mode ? gate_tick && gate_active : sel_edge);
  wire accum_wrap = count_inc && !wr_count && count_reg == 8'hff;

  // flag set and clear; a set wins over a same-cycle clear
  wire [7:0] flag_clr = wr_flag ? wdata_reg & FLAG_MASK : 8'h00;
  wire [7:0] flag_set = {main_count_wrap, periodic_timeout, accum_wrap,
                         ctrl_reg.accum_enable && sel_edge, 4'h0};
  assign flag_next = ((flag_reg & ~flag_clr) | flag_set) & FLAG_MASK;
  assign mask_next = wr_mask ? mask_t'(wdata_reg & MASK_WMASK) : mask_reg;
  assign ctrl_next = wr_ctrl ? ctrl_t'(wdata_reg & CTRL_WMASK) : ctrl_reg;
  assign count_next = wr_count ? wdata_reg : count_inc ? count_reg + 8'h01 : count_reg;
  wire irq_next = |(flag_reg & 8'(mask_reg) & FLAG_MASK);

  // axi write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= !aw_held_next;
      wready_reg <= !w_held_next;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_sel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // captured write payload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else begin
      if (aw_take) awaddr_reg <= awaddr;
      if (w_take) wdata_reg <= wdata[7:0];
      if (w_take) wstrb0_reg <= wstrb[0];
    end
  end

  // axi read side, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_sel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end else begin
      arready_reg <= !rvalid_reg;
    end
  end

  // registers, flags, counter and request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= mask_t'(MASK_RESET);
      ctrl_reg <= ctrl_t'(CTRL_RESET);
      flag_reg <= FLAG_RESET;
      count_reg <= COUNT_RESET;
      irq_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      count_reg <= count_next;
      irq_reg <= irq_next;
    end
  end

  // free-running dividers, touched only by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_div_reg <= '0;
      gate_div_reg <= '0;
    end else begin
      tick_div_reg <= tick_div_reg + DIV_W'(1);
      gate_div_reg <= gate_div_reg + GATE_DIV_W'(1);
    end
  end

  // two-stage synchroniser and edge history for the accumulator pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= accum_input_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // output drive
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq = irq_reg;
  assign main_prescale_select = mask_reg.main_prescale_select;
  assign capture4_compare5_select = ctrl_reg.capture4_compare5_select;

  // cycles since reset release, saturating, for the first-timeout check
  logic [DIV_W:0] since_rst_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) since_rst_reg <= '0;
    else if (!since_rst_reg[DIV_W]) since_rst_reg <= since_rst_reg + (DIV_W+1)'(1);
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_ready;
    aw_held_reg && w_held_reg && !bvalid_reg;
  endsequence
  sequence s_flag_write(int b);
    s_write_ready ##0 wr_flag && wdata_reg[b];
  endsequence

  a_periodic_sets: assert property (periodic_timeout |=> flag_reg[BIT_PERIODIC])
    else $error("periodic timeout did not set flag");
  a_first_tick_late: assert property (
    $rose(flag_reg[BIT_PERIODIC]) && !since_rst_reg[DIV_W]
    |-> since_rst_reg >= (DIV_W+1)'((DIV_W+1)'(1) << TICK_BASE_SHIFT))
    else $error("periodic flag set before one full interval");
  a_tick_free_run: assert property (
    !since_rst_reg[DIV_W] |-> tick_div_reg == DIV_W'(since_rst_reg))
    else $error("periodic divider disturbed");
  a_flag_clear_one: assert property (
    s_flag_write(BIT_PERIODIC) ##0 !periodic_timeout |=> !flag_reg[BIT_PERIODIC])
    else $error("write of one did not clear flag");
  a_reserved_zero: assert property (
    flag_reg[3:0] == 4'h0 && !ctrl_reg.unused7 && !ctrl_reg.unused3 && mask_reg.unused == 2'h0)
    else $error("reserved bit set");
  a_wrap_flag_sets: assert property (main_count_wrap |=> flag_reg[BIT_WRAP])
    else $error("main count wrap lost");
  a_irq_gating: assert property (
    ##1 irq == $past(|(flag_reg[7:4] & 4'(8'(mask_reg) >> 4))))
    else $error("interrupt output not flag and enable");
  a_event_count: assert property (
    ctrl_reg.accum_enable && !ctrl_reg.accum_mode && sel_edge && !wr_count
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("selected edge not counted");
  a_gate_inhibit: assert property (
    ctrl_reg.accum_mode && (!gate_active || !gate_tick) && !wr_count |=> $stable(count_reg))
    else $error("gated count moved while inhibited");
  a_accum_roll: assert property (
    accum_wrap |=> flag_reg[BIT_ACCUM_WRAP] && count_reg == 8'h00)
    else $error("accumulator rollover not flagged");
  a_edge_flag_sets: assert property (
    ctrl_reg.accum_enable && sel_edge |=> flag_reg[BIT_ACCUM_EDGE])
    else $error("edge flag not set");
  a_count_load: assert property (wr_count |=> count_reg == $past(wdata_reg))
    else $error("count load lost");
  a_write_answer: assert property (s_write_ready |=> bvalid_reg)
    else $error("write response missing");

  // flag clearing, set priority and request
  a_flag_set_wins: assert property (
    s_flag_write(BIT_PERIODIC) ##0 periodic_timeout |=> flag_reg[BIT_PERIODIC])
    else $error("timeout lost to a same-cycle clear");
  a_flag_zero_write: assert property (
    wr_flag && !wdata_reg[BIT_PERIODIC] && flag_reg[BIT_PERIODIC] |=> flag_reg[BIT_PERIODIC])
    else $error("write of zero cleared flag");
  a_wrap_clear: assert property (
    s_flag_write(BIT_WRAP) ##0 !main_count_wrap |=> !flag_reg[BIT_WRAP])
    else $error("write of one did not clear wrap flag");
  a_edge_clear: assert property (
    s_flag_write(BIT_ACCUM_EDGE) ##0 !(ctrl_reg.accum_enable && sel_edge)
    |=> !flag_reg[BIT_ACCUM_EDGE])
    else $error("write of one did not clear edge flag");
  a_irq_when_set: assert property (
    flag_reg[BIT_PERIODIC] && mask_reg.periodic_int_enable |=> irq)
    else $error("periodic request missing");

  // register loads keep only the writable bits
  a_mask_load: assert property (
    wr_mask |=> 8'(mask_reg) == ($past(wdata_reg) & MASK_WMASK))
    else $error("mask load wrong");
  a_ctrl_load: assert property (
    wr_ctrl |=> 8'(ctrl_reg) == ($past(wdata_reg) & CTRL_WMASK))
    else $error("control load wrong");

  // accumulator input and counting
  a_pin_two_stage: assert property (
    since_rst_reg > (DIV_W+1)'(2) |-> pin_sync_reg == $past(accum_input_pin, 2))
    else $error("pin synchroniser depth wrong");
  a_gate_count: assert property (
    ctrl_reg.accum_enable && ctrl_reg.accum_mode && gate_tick && gate_active && !wr_count
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("gated tick not counted");
  a_disabled_hold: assert property (
    !ctrl_reg.accum_enable && !wr_count |=> $stable(count_reg))
    else $error("count moved while disabled");

  // bus answers and refusals
  sequence s_read_taken;
    arvalid && arready_reg;
  endsequence
  a_read_answer: assert property (
    s_read_taken |=> rvalid_reg && rdata_reg[31:8] == 24'h00_0000)
    else $error("read answer missing");
  a_read_refuse: assert property (rvalid_reg |-> !arready_reg)
    else $error("read taken while answer pending");
  a_write_refuse: assert property (aw_held_reg |-> !awready_reg)
    else $error("address taken while one is held");
endmodule

/* logic/tick_pkg.sv */
package tick_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MASK = 8'h24;
  localparam logic [7:0] IDX_FLAG = 8'h25;
  localparam logic [7:0] IDX_CTRL = 8'h26;
  localparam logic [7:0] IDX_COUNT = 8'h27;
  localparam int IDX_LSB = 2;
  // flag and enable bit positions, shared by mask and flag registers
  localparam int BIT_WRAP = 7;
  localparam int BIT_PERIODIC = 6;
  localparam int BIT_ACCUM_WRAP = 5;
  localparam int BIT_ACCUM_EDGE = 4;
  // writable and readable bits per register
  localparam logic [7:0] MASK_WMASK = 8'hf3;
  localparam logic [7:0] FLAG_MASK = 8'hf0;
  localparam logic [7:0] CTRL_WMASK = 8'h77;
  // reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // timing: periodic base divide is 2**13, gated divide is 64 = 2**6
  localparam int TICK_BASE_SHIFT_DEF = 13;
  localparam int TICK_RATE_STEPS = 3;
  localparam int GATE_DIV_W = 6;
  localparam int ADDR_W_DEF = 8;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic unused7;
    logic accum_enable;
    logic accum_mode;
    logic accum_edge_select;
    logic unused3;
    logic capture4_compare5_select;
    logic [1:0] tick_rate_select;
  } ctrl_t;

  typedef struct packed {
    logic wrap_int_enable;
    logic periodic_int_enable;
    logic accum_wrap_int_enable;
    logic accum_edge_int_enable;
    logic [1:0] unused;
    logic [1:0] main_prescale_select;
  } mask_t;

  typedef enum logic [2:0] {SEL_NONE, SEL_MASK, SEL_FLAG, SEL_CTRL, SEL_COUNT} reg_sel_t;
endpackage

/* test/periodic_tick_and_pulse_counter_test.sv */
module periodic_tick_and_pulse_counter_test import tick_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SH = 4;
  logic aclk = 1'b0, aresetn = 1'b0, pin = 1'b0, wrap_p = 1'b0, irq_d = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, capsel;
  logic [1:0] bresp, rresp, psel;
  int n_fail = 0, compares = 0, cyc = 0, rise_t = 0, rise_n = 0;

  periodic_tick_and_pulse_counter #(.TICK_BASE_SHIFT(SH)) i_periodic_tick_and_pulse_counter (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .accum_input_pin(pin),
    .main_count_wrap(wrap_p), .irq(irq), .main_prescale_select(psel),
    .capture4_compare5_select(capsel)
  );

  // 250 MHz bus clock
  initial begin
    forever #2 aclk = ~aclk;
  end

  // cycle count since reset release and irq rise stamps
  always @(posedge aclk) begin
    irq_d <= irq;
    cyc <= aresetn ? cyc + 1 : 0;
    if (irq && !irq_d) begin
      rise_t <= cyc;
      rise_n <= rise_n + 1;
    end
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic timeout();
    n_fail++;
    tally_and_finish();
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] ba(input logic [7:0] i);
    return {i[5:0], 2'b00};
  endfunction

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (!bvalid) timeout();
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (!rvalid) timeout();
    rready <= 1'b0;
    check("rresp", rresp, er);
    check("rdata high", rdata[31:8], 0);
    d = rdata[7:0];
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    logic [7:0] d;
    rd(a, d, RESP_OKAY);
    check(nm, d & m, e);
  endtask

  task automatic ck_irq(input logic e);
    repeat (2) @(posedge aclk);
    check("irq", irq, e);
  endtask

  task automatic wait_rise();
    int n0, n;
    n0 = rise_n;
    n = 0;
    while (rise_n == n0 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    if (rise_n == n0) timeout();
  endtask

  // pin toggles every cycle: selected edges at half the bus rate
  task automatic tog(input int k);
    repeat (k) begin
      @(posedge aclk);
      pin <= ~pin;
    end
    repeat (5) @(posedge aclk);
  endtask

  // main sequence
  initial begin
    int t1;
    logic [7:0] d;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc("flag rst", ba(IDX_FLAG), 8'hff, 8'h00);
    rc("mask rst", ba(IDX_MASK), 8'hff, 8'h00);
    rc("ctrl rst", ba(IDX_CTRL), 8'hff, 8'h00);
    wr(ba(IDX_MASK), 8'hff);
    rc("mask bits", ba(IDX_MASK), 8'hff, 8'hf3);
    check("prescale", psel, 2'h3);
    wr(ba(IDX_CTRL), 8'hff);
    rc("ctrl bits", ba(IDX_CTRL), 8'hff, 8'h77);
    check("capsel", capsel, 1'b1);
    wr(ba(IDX_FLAG), 8'hff);
    rc("flag low", ba(IDX_FLAG), 8'h0f, 8'h00);
    wr(8'h80, 8'h55, RESP_SLVERR);
    rd(8'h91, d, RESP_SLVERR);
    check("unmapped", d, 0);
    wr(ba(IDX_MASK), 8'h00);
    wr(ba(IDX_CTRL), 8'h00);
    check("capsel", capsel, 1'b0);
    // second reset, first tick after one whole period
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wr(ba(IDX_MASK), 8'h40);
    wait_rise();
    check("first tick", 32'(rise_t >= 15 && rise_t <= 19), 1);
    for (int r = 0; r < 4; r++) begin
      wr(ba(IDX_MASK), 8'h00);
      wr(ba(IDX_CTRL), 8'(r));
      wr(ba(IDX_FLAG), 8'h40);
      wr(ba(IDX_MASK), 8'(8'h40 | r));
      wait_rise();
      wr(ba(IDX_FLAG), 8'h40);
      wait_rise();
      t1 = rise_t;
      repeat (r * 3) @(posedge aclk);
      wr(ba(IDX_FLAG), 8'h40);
      wait_rise();
      check("period", rise_t - t1, 32'(1 << (SH + r)));
    end
    wr(ba(IDX_MASK), 8'h00);
    ck_irq(1'b0);
    rc("tick flag", ba(IDX_FLAG), 8'h40, 8'h40);
    wr(ba(IDX_MASK), 8'h40);
    ck_irq(1'b1);
    wr(ba(IDX_FLAG), 8'h00);
    ck_irq(1'b1);
    wr(ba(IDX_FLAG), 8'hbf);
    ck_irq(1'b1);
    wr(ba(IDX_FLAG), 8'h40);
    ck_irq(1'b0);
    // main timer wrap pulse
    wr(ba(IDX_MASK), 8'h80);
    wrap_p <= 1'b1;
    @(posedge aclk);
    wrap_p <= 1'b0;
    ck_irq(1'b1);
    rc("wrap flag", ba(IDX_FLAG), 8'h80, 8'h80);
    wr(ba(IDX_FLAG), 8'h80);
    ck_irq(1'b0);
    wr(ba(IDX_MASK), 8'h00);
    // event counting, both edges, with roll over
    for (int e = 0; e < 2; e++) begin
      wr(ba(IDX_CTRL), 8'(8'h40 | (e << 4)));
      wr(ba(IDX_COUNT), 8'hfb);
      wr(ba(IDX_FLAG), 8'h30);
      tog(10);
      rc("event count", ba(IDX_COUNT), 8'hff, 8'h00);
      rc("accum flags", ba(IDX_FLAG), 8'h30, 8'h30);
    end
    wr(ba(IDX_CTRL), 8'h10);
    wr(ba(IDX_COUNT), 8'h33);
    tog(10);
    rc("disabled", ba(IDX_COUNT), 8'hff, 8'h33);
    // gated time accumulation, both inhibit levels
    for (int g = 0; g < 2; g++) begin
      pin <= 1'(g);
      wr(ba(IDX_CTRL), 8'(8'h60 | (g << 4)));
      wr(ba(IDX_COUNT), 8'h00);
      repeat (80) @(posedge aclk);
      rc("inhibited", ba(IDX_COUNT), 8'hff, 8'h00);
      pin <= ~1'(g);
      repeat (640) @(posedge aclk);
      pin <= 1'(g);
      repeat (5) @(posedge aclk);
      rc("gated count", ba(IDX_COUNT), 8'hff, 8'h0a);
    end
    tally_and_finish();
  end
endmodule
